// ---- common/cad_pkg.sv ----
// package for the configuration address decoder: constants and carriers
// Summary of operation
// - 32-bit address register at I/O 0CF8h, reset zero, written by dword only.
// - byte or word access there leaves register alone, passes to hub link as I/O.
// - top bit one enables configuration cycles; zero disables them.
// - bits 23:16 are bus number; zero targets hub agent or internal device.
// - bus zero, device not 0,1,2,3,6: forward configuration cycle on hub link.
// - bus zero, device 0,1,2,3 or 6: route to that internal device.
// - nonzero bus equal to secondary bus: Type 0 cycle on graphics port.
// - bus above secondary, at or below subordinate: Type 1 on graphics port.
// - nonzero bus outside that range: Type 1 cycle on hub link.
// - hub-link Type 1 request carries 01 in its two lowest address bits.
// - Type 0 drives one-hot select, line 16 for device 0 up to line 31 for device 15.
// - Type 0 device above 15: no select asserted, master abort recorded.
// - device number goes to address bits 15:11 of hub and Type 1 cycles.
// - function number goes to address bits 10:8 of outgoing cycles.
// - internal device accesses with nonzero function number are ignored.
// - register number goes to address bits 7:2 of outgoing cycles.
// - enabled data window accesses at 0CFCh become configuration accesses.
package cad_pkg;
    localparam logic [15:0] CAD_ADDR_IO = 16'h0CF8;
    localparam logic [15:0] CAD_DATA_IO = 16'h0CFC;
    localparam logic [31:0] CAD_ADDR_RST = 32'h00000000;
    localparam int CAD_EN_BIT = 31;
    localparam int CAD_BUS_LSB = 16;
    localparam int CAD_DEV_LSB = 11;
    localparam int CAD_FN_LSB = 8;
    localparam int CAD_REG_LSB = 2;
    localparam logic [1:0] CAD_T0_LOW = 2'h0;
    localparam logic [1:0] CAD_T1_LOW = 2'h1;
    localparam logic [4:0] CAD_MAX_SEL_DEV = 5'h0F;
    localparam logic [3:0] CAD_BE_DWORD = 4'hF;
    localparam logic [31:0] CAD_RESERVED_MASK = 32'h80FFFFFC;

    // where a data-window or address access is sent
    typedef enum logic [2:0] {
        CAD_TGT_NONE = 3'b000,
        CAD_TGT_INTERNAL = 3'b001,
        CAD_TGT_HUB_CFG = 3'b010,
        CAD_TGT_GFX_T0 = 3'b011,
        CAD_TGT_GFX_T1 = 3'b100,
        CAD_TGT_HUB_IO = 3'b101
    } cad_target_t;

    // host I/O request
    typedef struct packed {
        logic valid;
        logic write;
        logic [15:0] addr;
        logic [3:0] be;
        logic [31:0] wdata;
    } cad_io_req_t;

    // routed cycle
    typedef struct packed {
        logic valid;
        cad_target_t target;
        logic write;
        logic [31:0] addr;
        logic [3:0] be;
        logic [31:0] wdata;
        logic [4:0] int_dev;
        logic [15:0] idsel;
        logic master_abort;
    } cad_route_t;

    // bus-number classification
    function automatic cad_target_t cad_classify(input logic [7:0] bus,
            input logic [4:0] dev, input logic [7:0] sec,
            input logic [7:0] sub);
        cad_target_t t;
        t = CAD_TGT_HUB_CFG;
        if (bus == 8'h00) begin
            if (dev == 5'h00 || dev == 5'h01 || dev == 5'h02 ||
                    dev == 5'h03 || dev == 5'h06) begin
                t = CAD_TGT_INTERNAL;
            end
        end else if (bus == sec) begin
            t = CAD_TGT_GFX_T0;
        end else if (bus > sec && bus <= sub) begin
            t = CAD_TGT_GFX_T1;
        end
        return t;
    endfunction
endpackage

// ---- hdl/cad_idsel.sv ----
// one-hot select decoder for Type 0 graphics port cycles
`timescale 1ns/10ps
module cad_idsel (
    // device number
    input wire logic [4:0] i_dev,
    // one-hot select for address lines 31:16
    output logic [15:0] o_idsel
);
    import cad_pkg::*;
    // numbers above 15 select nothing so the cycle master-aborts
    assign o_idsel = (i_dev > CAD_MAX_SEL_DEV) ? 16'h0000 :
                     (16'h0001 << i_dev[3:0]);
endmodule

// ---- hdl/cad_decoder.sv ----
// configuration address register and configuration cycle router
`timescale 1ns/10ps
module cad_decoder (
    // clock and reset
    input wire logic i_ref_clk,
    input wire logic i_rstn,
    // host I/O request, same clock domain
    input wire cad_pkg::cad_io_req_t i_io_req,
    // bridge device 1 bus numbers
    input wire logic [7:0] i_sec_bus,
    input wire logic [7:0] i_sub_bus,
    // routed cycle and readback
    output cad_pkg::cad_route_t o_route,
    output logic o_rdata_valid,
    output logic [31:0] o_rdata,
    // current enable bit
    output logic o_config_enable_bit
);
    import cad_pkg::*;

    logic [31:0] config_address_reg;
    logic [31:0] addr_next;
    cad_route_t route_reg;
    cad_route_t route_next;
    logic rvalid_reg;
    logic [31:0] rdata_reg;
    logic [15:0] idsel_w;

    // request decode
    wire hit_addr = i_io_req.valid && i_io_req.addr == CAD_ADDR_IO;
    wire hit_data = i_io_req.valid && i_io_req.addr == CAD_DATA_IO;
    wire dword = i_io_req.be == CAD_BE_DWORD;
    wire addr_wr = hit_addr && dword && i_io_req.write;
    wire addr_rd = hit_addr && dword && !i_io_req.write;
    wire pass_io = hit_addr && !dword;
    wire cfg_en = config_address_reg[CAD_EN_BIT];

    // stored fields
    wire [7:0] bus_f = config_address_reg[23:CAD_BUS_LSB];
    wire [4:0] dev_f = config_address_reg[15:CAD_DEV_LSB];
    wire [2:0] fn_f = config_address_reg[10:CAD_FN_LSB];
    wire [5:0] reg_f = config_address_reg[7:CAD_REG_LSB];
    wire cad_target_t cls = cad_classify(bus_f, dev_f, i_sec_bus, i_sub_bus);
    // fields copied into the outgoing address
    wire [31:0] t1_addr = {8'h00, bus_f, dev_f, fn_f, reg_f, CAD_T1_LOW};
    wire [31:0] t0_addr = {idsel_w, 5'h00, fn_f, reg_f, CAD_T0_LOW};

    cad_idsel u_idsel (
        .i_dev(dev_f),
        .o_idsel(idsel_w)
    );

    // reserved bits are forced to zero on write
    assign addr_next = addr_wr ? (i_io_req.wdata & CAD_RESERVED_MASK)
                               : config_address_reg;

    // route selection for the current request
    always_comb begin
        route_next = '0;
        route_next.write = i_io_req.write;
        route_next.be = i_io_req.be;
        route_next.wdata = i_io_req.wdata;
        if (pass_io || (hit_data && !cfg_en)) begin
            // plain I/O forwarded downstream
            route_next.valid = 1'b1;
            route_next.target = CAD_TGT_HUB_IO;
            route_next.addr = {16'h0000, i_io_req.addr};
        end else if (hit_data) begin
            // enabled window becomes a configuration access
            route_next.target = cls;
            route_next.valid = 1'b1;
            case (cls)
                CAD_TGT_INTERNAL: begin
                    // nonzero function is dropped
                    route_next.valid = (fn_f == 3'h0);
                    route_next.int_dev = dev_f;
                    route_next.addr = {24'h000000, reg_f, 2'h0};
                end
                CAD_TGT_GFX_T0: begin
                    route_next.addr = t0_addr;
                    route_next.idsel = idsel_w;
                    route_next.master_abort = (idsel_w == 16'h0000);
                end
                default: begin
                    // hub and graphics Type 1 share the layout
                    route_next.addr = t1_addr;
                end
            endcase
        end
    end

    // address register and outputs
    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            config_address_reg <= CAD_ADDR_RST;
            route_reg <= '0;
            rvalid_reg <= 1'b0;
            rdata_reg <= 32'h00000000;
        end else begin
            config_address_reg <= addr_next;
            route_reg <= route_next;
            rvalid_reg <= addr_rd;
            rdata_reg <= addr_rd ? config_address_reg : 32'h00000000;
        end
    end

    assign o_route = route_reg;
    assign o_rdata_valid = rvalid_reg;
    assign o_rdata = rdata_reg;
    assign o_config_enable_bit = config_address_reg[CAD_EN_BIT];

    // word or byte writes never touch the register
    a_partial_no_update: assert property (@(posedge i_ref_clk)
        disable iff (!i_rstn)
        pass_io |=> $stable(config_address_reg))
        else $error("partial access changed address register");

    a_dword_write_load: assert property (@(posedge i_ref_clk)
        disable iff (!i_rstn)
        addr_wr |=> config_address_reg ==
            ($past(i_io_req.wdata) & CAD_RESERVED_MASK))
        else $error("dword write not stored");

    a_disabled_plain_io: assert property (@(posedge i_ref_clk)
        disable iff (!i_rstn)
        (hit_data && !cfg_en) |=> o_route.target == CAD_TGT_HUB_IO)
        else $error("disabled window not plain I/O");

    a_internal_fn_zero: assert property (@(posedge i_ref_clk)
        disable iff (!i_rstn)
        (o_route.valid && o_route.target == CAD_TGT_INTERNAL)
        |-> o_route.addr[31:8] == 24'h000000)
        else $error("internal access malformed");

    a_hub_type1_low: assert property (@(posedge i_ref_clk)
        disable iff (!i_rstn)
        (hit_data && cfg_en && cls == CAD_TGT_HUB_CFG)
        |=> o_route.valid && o_route.addr[1:0] == 2'b01
            && o_route.addr[15:11] == $past(dev_f))
        else $error("hub Type 1 address wrong");

    a_idsel_onehot: assert property (@(posedge i_ref_clk)
        disable iff (!i_rstn)
        (o_route.valid && o_route.target == CAD_TGT_GFX_T0)
        |-> ($onehot(o_route.idsel) != o_route.master_abort))
        else $error("Type 0 select not one-hot");

    a_gfx_t0_route: assert property (@(posedge i_ref_clk)
        disable iff (!i_rstn)
        (hit_data && cfg_en && bus_f != 8'h00 && bus_f == i_sec_bus)
        |=> o_route.target == CAD_TGT_GFX_T0
            && o_route.addr[10:2] == $past({fn_f, reg_f}))
        else $error("Type 0 routing wrong");

    a_bus_zero_route: assert property (@(posedge i_ref_clk)
        disable iff (!i_rstn)
        (hit_data && cfg_en && bus_f == 8'h00 && dev_f > 5'h06)
        |=> o_route.target == CAD_TGT_HUB_CFG)
        else $error("bus zero forward wrong");

    // dword read answers one cycle later with the stored value
    a_readback_pulse: assert property (@(posedge i_ref_clk)
        disable iff (!i_rstn)
        addr_rd |=> o_rdata_valid && o_rdata == $past(config_address_reg))
        else $error("address readback wrong");

    // reserved bits can never be seen set in the register
    a_reserved_zero: assert property (@(posedge i_ref_clk)
        disable iff (!i_rstn)
        (config_address_reg & ~CAD_RESERVED_MASK) == 32'h00000000)
        else $error("reserved address bits set");

    // partial access goes out as plain I/O to the address location
    a_partial_route: assert property (@(posedge i_ref_clk)
        disable iff (!i_rstn)
        pass_io |=> o_route.valid && o_route.target == CAD_TGT_HUB_IO
            && o_route.addr[15:0] == CAD_ADDR_IO)
        else $error("partial access not passed on");

    // internal device picked by number, dropped on nonzero function
    a_internal_select: assert property (@(posedge i_ref_clk)
        disable iff (!i_rstn)
        (hit_data && cfg_en && cls == CAD_TGT_INTERNAL)
        |=> o_route.target == CAD_TGT_INTERNAL
            && o_route.valid == ($past(fn_f) == 3'h0)
            && o_route.int_dev == $past(dev_f))
        else $error("internal route wrong");

    // bus inside the bridge window but above secondary: Type 1 there
    a_gfx_t1_route: assert property (@(posedge i_ref_clk)
        disable iff (!i_rstn)
        (hit_data && cfg_en && bus_f != 8'h00 && bus_f > i_sec_bus
            && bus_f <= i_sub_bus)
        |=> o_route.target == CAD_TGT_GFX_T1
            && o_route.addr[15:11] == $past(dev_f)
            && o_route.addr[23:16] == $past(bus_f))
        else $error("graphics Type 1 wrong");

    // bus outside the bridge window leaves on the hub link
    a_hub_type1_range: assert property (@(posedge i_ref_clk)
        disable iff (!i_rstn)
        (hit_data && cfg_en && bus_f != 8'h00 && bus_f != i_sec_bus
            && (bus_f < i_sec_bus || bus_f > i_sub_bus))
        |=> o_route.target == CAD_TGT_HUB_CFG)
        else $error("hub Type 1 range wrong");

    // enabled window never leaves as plain I/O
    a_enabled_window: assert property (@(posedge i_ref_clk)
        disable iff (!i_rstn)
        (hit_data && cfg_en) |=> o_route.target != CAD_TGT_HUB_IO)
        else $error("enabled window not converted");

    // unrelated addresses produce no routed cycle
    a_idle_no_route: assert property (@(posedge i_ref_clk)
        disable iff (!i_rstn)
        (!hit_addr && !hit_data) |=> !o_route.valid)
        else $error("route without request");

    // select lines sit in the upper address half of a Type 0 cycle
    a_t0_idsel_field: assert property (@(posedge i_ref_clk)
        disable iff (!i_rstn)
        (o_route.valid && o_route.target == CAD_TGT_GFX_T0)
        |-> o_route.addr[31:16] == o_route.idsel)
        else $error("select not on upper lines");
endmodule

// ---- sim/cad_far_side.sv ----
// far-side model: hub link and graphics port ends taking routed cycles
`timescale 1ns/10ps
module cad_far_side (
    // clock and reset
    input wire logic i_ref_clk,
    input wire logic i_rstn,
    // routed cycle from the decoder
    input wire cad_pkg::cad_route_t i_route,
    // count of configuration cycles taken
    output logic [15:0] o_cfg_seen
);
    import cad_pkg::*;
    // both ends accept at once; no wait states, so nothing to refuse
    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_cfg_seen <= 16'h0000;
        end else if (i_route.valid && i_route.target inside
                {CAD_TGT_HUB_CFG, CAD_TGT_GFX_T0, CAD_TGT_GFX_T1}) begin
            o_cfg_seen <= o_cfg_seen + 16'h0001;
        end
    end
endmodule

// ---- sim/config_address_decoder_bench.sv ----
// self-checking bench for the configuration address decoder
`timescale 1ns/10ps
module config_address_decoder_bench;
    import cad_pkg::*;
    logic i_ref_clk = 1'b0;
    logic i_rstn = 1'b0;
    cad_io_req_t i_io_req = '0;
    logic [7:0] i_sec_bus = 8'h01;
    logic [7:0] i_sub_bus = 8'h01;
    cad_route_t o_route;
    logic o_rdata_valid;
    logic [31:0] o_rdata;
    logic o_config_enable_bit;
    logic [15:0] cfg_seen;
    logic [31:0] seed = 32'h00000052;
    int err_total = 0;
    int num_checks = 0;
    // clock, 25 ns period
    always #12.5 i_ref_clk = ~i_ref_clk;
    cad_decoder u_dut (.i_ref_clk(i_ref_clk), .i_rstn(i_rstn),
        .i_io_req(i_io_req), .i_sec_bus(i_sec_bus), .i_sub_bus(i_sub_bus),
        .o_route(o_route), .o_rdata_valid(o_rdata_valid),
        .o_rdata(o_rdata), .o_config_enable_bit(o_config_enable_bit));
    cad_far_side u_far (.i_ref_clk(i_ref_clk), .i_rstn(i_rstn),
        .i_route(o_route), .o_cfg_seen(cfg_seen));
    // lfsr step for repeatable stimulus
    function automatic logic [31:0] rnd(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    // expected target worked out from the address value
    function automatic logic [2:0] exp_tgt(input logic [31:0] a);
        if (!a[31]) return 3'h5;
        if (a[23:16] == 8'h00)
            return (a[15:11] inside {5'h00, 5'h01, 5'h02, 5'h03, 5'h06})
                ? 3'h1 : 3'h2;
        if (a[23:16] == i_sec_bus) return 3'h3;
        if (a[23:16] > i_sec_bus && a[23:16] <= i_sub_bus) return 3'h4;
        return 3'h2;
    endfunction
    // expected outgoing address; one-hot select only below device 16
    function automatic logic [31:0] exp_addr(input logic [31:0] a);
        logic [15:0] sel;
        sel = a[15] ? 16'h0000 : 16'h0001 << a[14:11];
        case (exp_tgt(a))
            3'h1: return {24'h000000, a[7:2], 2'h0};
            3'h3: return {sel, 5'h00, a[10:2], 2'h0};
            3'h5: return {16'h0000, CAD_DATA_IO};
            default: return {8'h00, a[23:2], 2'h1};
        endcase
    endfunction
    task automatic chk(input string n, input logic [31:0] e,
            input logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            err_total++;
            $display("MISMATCH %s exp %h got %h", n, e, g);
        end
    endtask
    // one request; valid stays up so back-to-back calls never clash
    task automatic io(input logic w, input logic [15:0] ad,
            input logic [3:0] be, input logic [31:0] d);
        i_io_req = '{1'b1, w, ad, be, d};
        @(negedge i_ref_clk);
    endtask
    task automatic idle();
        i_io_req.valid = 1'b0;
        @(negedge i_ref_clk);
    endtask
    task automatic results();
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    // watchdog: the run needs well under 1000 cycles
    initial begin
        #(25 * 4000);
        err_total++;
        results();
    end
    initial begin
        logic [31:0] a;
        logic [7:0] b;
        logic [2:0] t;
        int n_cfg;
        n_cfg = 0;
        repeat (5) @(negedge i_ref_clk);
        i_rstn = 1'b1;
        io(1'b0, CAD_ADDR_IO, CAD_BE_DWORD, 32'h00000000);
        chk("rdata_valid", 32'h1, {31'h0, o_rdata_valid});
        chk("reset value", CAD_ADDR_RST, o_rdata);
        idle();
        chk("rdata idle", 32'h0, {31'h0, o_rdata_valid});
        $display("test reset done");
        for (int i = 0; i < 80; i++) begin
            seed = rnd(seed);
            i_sec_bus = 8'h01 + {1'b0, seed[6:0]};
            i_sub_bus = i_sec_bus + {4'h0, seed[10:7]};
            // corner bus numbers around the bridge window
            case (seed[13:11])
                3'h0: b = 8'h00;
                3'h1: b = i_sec_bus;
                3'h2: b = i_sub_bus;
                3'h3: b = i_sec_bus - 8'h01;
                3'h4: b = i_sub_bus + 8'h01;
                default: b = seed[31:24];
            endcase
            a = {|seed[15:14], 7'h00, b, seed[20:16],
                seed[23:21] & {3{seed[24]}}, seed[30:25], 2'h0};
            io(1'b1, CAD_ADDR_IO, CAD_BE_DWORD, a);
            chk("enable", {31'h0, a[31]},
                {31'h0, o_config_enable_bit});
            io(1'b1, CAD_ADDR_IO, (seed[2] ? 4'h3 : 4'h1) << seed[1:0], ~a);
            chk("part tgt", 32'h5, {29'h0, o_route.target});
            chk("part addr", {16'h0000, CAD_ADDR_IO},
                o_route.addr);
            io(1'b0, CAD_ADDR_IO, CAD_BE_DWORD, 32'h00000000);
            chk("readback", a, o_rdata);
            chk("read pulse", 32'h1, {31'h0, o_rdata_valid});
            seed = rnd(seed);
            io(seed[5], CAD_DATA_IO, CAD_BE_DWORD, seed);
            t = exp_tgt(a);
            chk("valid", {31'h0, !(t == 3'h1 && a[10:8] != 3'h0)},
                {31'h0, o_route.valid});
            chk("target", {29'h0, t},
                {29'h0, o_route.target});
            chk("addr", exp_addr(a),
                o_route.addr);
            chk("write", {31'h0, seed[5]},
                {31'h0, o_route.write});
            chk("wdata", seed, o_route.wdata);
            chk("be", {28'h0, CAD_BE_DWORD},
                {28'h0, o_route.be});
            chk("abort", {31'h0, t == 3'h3 && a[15]},
                {31'h0, o_route.master_abort});
            if (t == 3'h3) begin
                chk("idsel", exp_addr(a) >> 16,
                    {16'h0, o_route.idsel});
            end
            if (t == 3'h1) begin
                chk("int_dev", {27'h0, a[15:11]},
                    {27'h0, o_route.int_dev});
            end
            if (o_route.valid === 1'b1 && t inside {3'h2, 3'h3, 3'h4})
                n_cfg++;
            io(1'b1, 16'h0CF4, CAD_BE_DWORD, seed);
            chk("other io", 32'h0, {31'h0, o_route.valid});
            idle();
            $display("test %0d done", i);
        end
        chk("far side cycles", n_cfg,
            {16'h0000, cfg_seen});
        results();
    end
endmodule
